// ===== verilog/fault_logic_params.svh
// Purpose: constants for the serial command and fault logic
// Assumes: 16-bit frames, MSB first, chip select low during a frame
// Notes: frame, address, field and reply flag positions and the filter count live here
// Function
// [R1] Driver two dither: retry bit 10, amplitude, frequency
// [R2] Thermal query returns per-output thermal flags
// [R3] Over-voltage flag reads 1 when present
// [R4] Fault bits 1=fault; top bit is combined fault
// [R5] Message two carries trim-state bit
// [R6] Open-load-off detected only while output off
// [R7] Pull-downs enabled at reset; detection needs them
// [R8] Disabled pull-down reports open-load as 0
// [R9] Pull-down off only by sleep or command
// [R10] Open-load filter delay 100 to 450 us
// [R11] Chip-select rise restarts filter timer
// [R12] Open-load fault latched until read
// [R13] Under-voltage clears outputs and control registers
// [R14] Battery over-voltage holds outputs off
// [R15] Unused addresses change nothing
// [R16] Host frames sixteen clocks, MSB first
`ifndef FAULT_LOGIC_PARAMS_SVH
`define FAULT_LOGIC_PARAMS_SVH
`define FRAME_BITS       16
`define ADDR_HI          15
`define ADDR_LO          11
`define ADDR_DRV2_CTRL   5'h18
`define ADDR_DRV2_DITHER 5'h19
`define ADDR_THERMAL_LIMIT_QUERY  5'h1C
`define ADDR_UNUSED_A    5'h1D
`define ADDR_UNUSED_B    5'h1E
`define ADDR_PULLDOWN    5'h1F
`define RETRY_BIT        10
`define AMP_HI           6
`define AMP_LO           4
`define FREQ_HI          3
`define FREQ_LO          0
`define FILTER_NS        100000
`define CLK_NS           100
`define FILTER_CYCLES    ((`FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W            11
`define PD_RESET         8'hFF
`define BIT_OV           0
`define BIT_TRIM         13
`define BIT_CALHI        10
`define BIT_CALLO        11
`define BIT_QOV          12
`define MSG_TOP          15
`define BIT_FIRST        5'h00
`define BIT_LAST         5'h0F
`define BIT_DONE         5'h10
`endif

// ===== verilog/fault_logic_pkg.sv
// Purpose: types for the serial command and fault logic
// Assumes: nothing beyond the params header
// Notes: types only
package fault_logic_pkg;
	typedef logic [15:0] word_t;
	typedef logic [4:0]  addr_t;
	typedef enum logic [1:0] {
		MSG_ONE   = 2'b00,
		MSG_TWO   = 2'b01,
		MSG_QUERY = 2'b10
	} reply_e;
endpackage

// ===== verilog/spi_fault_reporting_logic.sv
// Purpose: serial command decode and fault reporting
// Assumes: link clock from host; analog flags are asynchronous pins
// Notes: frame is captured on sclk, handed over by a ready flag qualified by chip-select rise
`timescale 1ns/1ns
`include "fault_logic_params.svh"
module spi_fault_reporting_logic
	import fault_logic_pkg::*;
#(
	parameter int NOUT   = 8,
	parameter int FILT_C = `FILTER_CYCLES
) (
	// System
	input  wire logic            ref_clk,
	input  wire logic            srst,
	// Serial link
	input  wire logic            sclk,
	input  wire logic            csN,
	input  wire logic            mosi,
	output logic                 miso,
	// Analog status pins
	input  wire logic [NOUT-1:0] openCmp,
	input  wire logic [NOUT-1:0] outCmd,
	input  wire logic [NOUT:0]   thermFlag,
	input  wire logic            overVolt,
	input  wire logic            underVolt,
	input  wire logic            sleepMode,
	input  wire logic            calHigh,
	input  wire logic            calLow,
	input  wire logic            trimmed,
	// Controls
	output logic [NOUT-1:0]      outEnable,
	output logic [NOUT-1:0]      pullDownEn,
	output logic                 retryTwo,
	output logic [2:0]           ditherAmp,
	output logic [3:0]           ditherFreq
);
	import fault_logic_pkg::*;

	// ==================================================
	// Link domain: shift in, count bits
	logic [15:0] shIn_r, shIn_nxt;
	logic [15:0] frame_r, frame_nxt;
	logic [4:0]  bitCnt_r, bitCnt_nxt;
	logic        frameOk_r, frameOk_nxt;
	word_t       reply_r;

	always_comb begin
		shIn_nxt    = {shIn_r[14:0], mosi}; // R16
		frame_nxt   = frame_r;
		frameOk_nxt = frameOk_r;
		// Count stops at sixteen; extra clocks are ignored
		bitCnt_nxt  = (bitCnt_r == `BIT_DONE) ? bitCnt_r : bitCnt_r + 5'h01;
		if (bitCnt_r == `BIT_FIRST) begin
			frameOk_nxt = 1'b0;
		end
		if (bitCnt_r == `BIT_LAST) begin
			frame_nxt   = shIn_nxt; // R16
			frameOk_nxt = 1'b1;
		end
	end

	// Chip select high clears the count; sclk is idle then, so nothing races it
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			bitCnt_r <= `BIT_FIRST;
		end else begin
			bitCnt_r <= bitCnt_nxt;
		end
	end

	// A frame cut short never raises frameOk_r and is dropped
	always_ff @(posedge sclk) begin
		shIn_r    <= shIn_nxt;
		frame_r   <= frame_nxt;
		frameOk_r <= frameOk_nxt;
	end

	// ==================================================
	// Crossings into ref_clk
	logic [1:0] okSync_r;
	logic [1:0] csSync_r;
	logic [NOUT-1:0] cmpS1_r, cmpS2_r;
	logic [NOUT:0]   thS1_r, thS2_r;
	logic [5:0]      mS1_r, mS2_r;
	// Only the second flop of each pair feeds logic
	always_ff @(posedge ref_clk) begin
		okSync_r  <= {okSync_r[0], frameOk_r};
		csSync_r  <= {csSync_r[0], csN};
		cmpS1_r   <= openCmp;
		cmpS2_r   <= cmpS1_r;
		thS1_r    <= thermFlag;
		thS2_r    <= thS1_r;
		mS1_r     <= {overVolt, underVolt, sleepMode, calHigh, calLow, trimmed};
		mS2_r     <= mS1_r;
	end
	logic csPrev_r;
	always_ff @(posedge ref_clk) begin
		csPrev_r <= csSync_r[1];
	end
	wire csRise   = csSync_r[1] & ~csPrev_r;
	// frame_r has stood still since the last link edge, so it is read directly
	wire frameNew = csRise & okSync_r[1];
	wire ovS      = mS2_r[5];
	wire uvS      = mS2_r[4];
	wire slpS     = mS2_r[3];

	// ==================================================
	// Control state
	logic [NOUT-1:0] pd_r, pd_nxt;
	logic            rt_r, rt_nxt;
	logic [2:0]      amp_r, amp_nxt;
	logic [3:0]      frq_r, frq_nxt;
	logic [NOUT-1:0] en_r, en_nxt;
	logic [NOUT-1:0] olLatch_r, olLatch_nxt;
	logic [`CNT_W-1:0] filt_r, filt_nxt;
	reply_e          sel_r, sel_nxt;
	logic [15:0]     cmdW;
	addr_t           cmdA;

	always_comb begin
		cmdW        = frame_r;
		cmdA        = cmdW[`ADDR_HI:`ADDR_LO];
		pd_nxt      = pd_r;
		rt_nxt      = rt_r;
		amp_nxt     = amp_r;
		frq_nxt     = frq_r;
		sel_nxt     = sel_r;
		olLatch_nxt = olLatch_r;
		filt_nxt    = (filt_r == `CNT_W'(FILT_C)) ? filt_r : filt_r + `CNT_W'(1);
		if (csRise) begin
			filt_nxt = '0; // R11
		end
		if (frameNew) begin
			sel_nxt = (sel_r == MSG_ONE) ? MSG_TWO : MSG_ONE;
			case (cmdA)
				`ADDR_DRV2_DITHER: begin
					rt_nxt  = cmdW[`RETRY_BIT]; // R1
					amp_nxt = cmdW[`AMP_HI:`AMP_LO];
					frq_nxt = cmdW[`FREQ_HI:`FREQ_LO];
				end
				`ADDR_THERMAL_LIMIT_QUERY: sel_nxt = MSG_QUERY; // R2
				`ADDR_PULLDOWN: pd_nxt = cmdW[NOUT-1:0];
				default: ; // R15
			endcase
			// Any accepted frame counts as the read: latched faults clear on it
			olLatch_nxt = '0;
		end
		// Latching: set wins over the frame clear; pull-down off wins over set
		for (int i = 0; i < NOUT; i++) begin
			if (filt_r == `CNT_W'(FILT_C) && pd_r[i] && !outCmd[i] && cmpS2_r[i]) begin
				olLatch_nxt[i] = 1'b1; // R6 R10 R12
			end
			if (!pd_r[i]) begin
				olLatch_nxt[i] = 1'b0; // R8
			end
		end
		// Under-voltage comes last so it overrides sleep and commands
		if (slpS) begin
			pd_nxt = '0; // R9
		end
		en_nxt = (ovS || uvS) ? '0 : outCmd; // R14
		if (uvS) begin
			pd_nxt  = `PD_RESET; // R13
			rt_nxt  = 1'b0;
			amp_nxt = '0;
			frq_nxt = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		// Reset: pull-downs on, outputs off
		if (srst) begin
			pd_r      <= `PD_RESET; // R7
			rt_r      <= 1'b0;
			amp_r     <= '0;
			frq_r     <= '0;
			en_r      <= '0;
			olLatch_r <= '0;
			filt_r    <= '0;
			sel_r     <= MSG_ONE;
		end else begin
			pd_r      <= pd_nxt;
			rt_r      <= rt_nxt;
			amp_r     <= amp_nxt;
			frq_r     <= frq_nxt;
			en_r      <= en_nxt;
			olLatch_r <= olLatch_nxt;
			filt_r    <= filt_nxt;
			sel_r     <= sel_nxt;
		end
	end

	// ==================================================
	// Reply word (registered on ref_clk; only its top bit drives miso)
	logic [15:0] rep_nxt;
	wire anyTh = |thS2_r;
	always_comb begin
		rep_nxt = '0;
		case (sel_r)
			// Query reply leaves the top three bits at zero
			MSG_QUERY: begin
				rep_nxt[NOUT:0]     = thS2_r; // R2
				rep_nxt[`BIT_CALHI] = mS2_r[2];
				rep_nxt[`BIT_CALLO] = mS2_r[1];
				rep_nxt[`BIT_QOV]   = ovS; // R3
			end
			MSG_TWO: begin
				rep_nxt[`MSG_TOP]  = ovS | anyTh; // R4
				rep_nxt[`BIT_TRIM] = mS2_r[0]; // R5
			end
			default: begin
				rep_nxt[`MSG_TOP] = ovS | anyTh; // R4
				rep_nxt[NOUT-1:0] = olLatch_r; // R12
			end
		endcase
	end
	always_ff @(posedge ref_clk) begin
		reply_r <= srst ? 16'h0000 : rep_nxt;
	end

	// ==================================================
	// Outputs
	logic [NOUT-1:0] outEn_nxt, pdOut_nxt;
	logic            miso_nxt;

	// All outputs leave from flops, one cycle behind the state
	always_comb begin
		outEn_nxt = srst ? '0 : en_r;
		pdOut_nxt = srst ? `PD_RESET : pd_r;
		miso_nxt  = reply_r[`MSG_TOP];
	end

	always_ff @(posedge ref_clk) begin
		outEnable  <= outEn_nxt;
		pullDownEn <= pdOut_nxt;
		retryTwo   <= rt_r;
		ditherAmp  <= amp_r;
		ditherFreq <= frq_r;
		miso       <= miso_nxt; // R4
	end

	// ==================================================
	// Checks
	a_pd_disabled_zero: assert property (@(posedge ref_clk) disable iff (srst) // R8
		!pd_r[0] |=> !olLatch_r[0])
		else $error("latched fault with pull-down off");

	a_ov_outputs_off: assert property (@(posedge ref_clk) disable iff (srst) // R14
		ovS |-> ##2 (outEnable == '0))
		else $error("outputs on during over-voltage");

	a_uv_pulldown_reset: assert property (@(posedge ref_clk) disable iff (srst) // R13
		uvS |=> (pd_r == `PD_RESET))
		else $error("pull-down not reset");

	a_cs_restart_timer: assert property (@(posedge ref_clk) disable iff (srst) // R11
		csRise |=> (filt_r == '0))
		else $error("timer not restarted");

	a_filter_blocks: assert property (@(posedge ref_clk) disable iff (srst) // R10
		(filt_r != `CNT_W'(FILT_C)) |=> !$rose(olLatch_r[0]))
		else $error("fault latched before timer");

	a_on_no_fault: assert property (@(posedge ref_clk) disable iff (srst) // R6
		(outCmd[0] && !olLatch_r[0] && !frameNew) |=> !olLatch_r[0])
		else $error("fault while on");

	a_sleep_pd_off: assert property (@(posedge ref_clk) disable iff (srst) // R9
		(slpS && !uvS) |=> (pd_r == '0))
		else $error("pull-down on in sleep");

	a_query_ov_bit: assert property (@(posedge ref_clk) disable iff (srst) // R3
		(sel_r == MSG_QUERY) |=> (reply_r[`BIT_QOV] == $past(ovS)))
		else $error("over-voltage bit wrong");

	a_dither_retry: assert property (@(posedge ref_clk) disable iff (srst) // R1
		(frameNew && cmdA == `ADDR_DRV2_DITHER && !uvS) |=> (rt_r == $past(cmdW[`RETRY_BIT])))
		else $error("retry bit not taken");

	a_dither_amp: assert property (@(posedge ref_clk) disable iff (srst) // R1
		(frameNew && cmdA == `ADDR_DRV2_DITHER && !uvS) |=> (amp_r == $past(cmdW[`AMP_HI:`AMP_LO])))
		else $error("amplitude not taken");

	a_dither_freq: assert property (@(posedge ref_clk) disable iff (srst) // R1
		(frameNew && cmdA == `ADDR_DRV2_DITHER && !uvS) |=> (frq_r == $past(cmdW[`FREQ_HI:`FREQ_LO])))
		else $error("frequency not taken");

	a_query_select: assert property (@(posedge ref_clk) disable iff (srst) // R2
		(frameNew && cmdA == `ADDR_THERMAL_LIMIT_QUERY) |=> (sel_r == MSG_QUERY))
		else $error("query reply not selected");

	a_query_therm: assert property (@(posedge ref_clk) disable iff (srst) // R2
		(sel_r == MSG_QUERY) |=> (reply_r[NOUT:0] == $past(thS2_r)))
		else $error("thermal flags wrong");

	a_query_cal_high: assert property (@(posedge ref_clk) disable iff (srst) // R2
		(sel_r == MSG_QUERY) |=> (reply_r[`BIT_CALHI] == $past(mS2_r[2])))
		else $error("calibration high bit wrong");

	a_query_cal_low: assert property (@(posedge ref_clk) disable iff (srst) // R2
		(sel_r == MSG_QUERY) |=> (reply_r[`BIT_CALLO] == $past(mS2_r[1])))
		else $error("calibration low bit wrong");

	a_msg_top_bit: assert property (@(posedge ref_clk) disable iff (srst) // R4
		(sel_r != MSG_QUERY) |=> (reply_r[`MSG_TOP] == $past(ovS | anyTh)))
		else $error("combined fault bit wrong");

	a_trim_state_bit: assert property (@(posedge ref_clk) disable iff (srst) // R5
		(sel_r == MSG_TWO) |=> (reply_r[`BIT_TRIM] == $past(mS2_r[0])))
		else $error("trim bit wrong");

	a_unused_ignored: assert property (@(posedge ref_clk) disable iff (srst) // R15
		(frameNew && (cmdA == `ADDR_UNUSED_A || cmdA == `ADDR_UNUSED_B) && !uvS && !slpS)
		|=> ($stable(rt_r) && $stable(amp_r) && $stable(frq_r) && $stable(pd_r)))
		else $error("unused address changed state");

	a_latch_holds: assert property (@(posedge ref_clk) disable iff (srst) // R12
		(olLatch_r[0] && pd_r[0] && !frameNew) |=> olLatch_r[0])
		else $error("latched fault lost");

	a_latch_clear: assert property (@(posedge ref_clk) disable iff (srst) // R12
		(frameNew && filt_r != `CNT_W'(FILT_C)) |=> (olLatch_r == '0))
		else $error("latched fault not cleared by frame");

	a_msg_one_latch: assert property (@(posedge ref_clk) disable iff (srst) // R12
		(sel_r == MSG_ONE) |=> (reply_r[NOUT-1:0] == $past(olLatch_r)))
		else $error("latched faults not in reply");

	a_uv_outputs_off: assert property (@(posedge ref_clk) disable iff (srst) // R13
		uvS |-> ##2 (outEnable == '0))
		else $error("outputs on during under-voltage");

	a_uv_retry_clear: assert property (@(posedge ref_clk) disable iff (srst) // R13
		uvS |=> !rt_r)
		else $error("retry bit kept in under-voltage");

	a_reset_pulldown: assert property (@(posedge ref_clk) // R7
		srst |=> (pd_r == `PD_RESET))
		else $error("pull-down off after reset");
endmodule

// ===== testbench/host_link_model.sv
// Purpose: host side of the serial link
// Assumes: link clock period 80 ns, held low outside frames
// Notes: data line inverted on release so no stale bit looks valid
`timescale 1ns/1ns
module host_link_model
	import fault_logic_pkg::*;
(
	// Link
	output logic sclk,
	output logic csN,
	output logic mosi
);
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		mosi = 1'b0;
	end
	// ========================================
	// Frame
	task automatic send(input word_t w);
		csN <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi <= w[i];
			#40 sclk <= 1'b1;
			#40 sclk <= 1'b0;
		end
		#40 csN <= 1'b1;
		mosi <= ~mosi;
	endtask
endmodule

// ===== testbench/tb_spi_fault_reporting_logic.sv
// Purpose: self-checking bench for the serial fault logic
// Assumes: filter count shortened to 10 cycles
// Notes: eight cycles after a frame covers sync plus register stages
`timescale 1ns/1ns
`include "fault_logic_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_spi_fault_reporting_logic;
	import fault_logic_pkg::*;
	logic       ref_clk   = 1'b0;
	logic       srst      = 1'b1;
	logic [7:0] outCmd    = 8'h00;
	logic       overVolt  = 1'b0;
	logic       underVolt = 1'b0;
	logic       sleepMode = 1'b0;
	logic [7:0] openCmp   = 8'h00;
	logic [8:0] thermFlag = 9'h000;
	logic       sclk, csN, mosi, miso, retryTwo;
	logic [7:0] outEnable, pullDownEn;
	logic [2:0] ditherAmp;
	logic [3:0] ditherFreq;
	int         errors    = 0;
	int         compares  = 0;
	always #50 ref_clk = ~ref_clk;
	host_link_model i_host (.sclk(sclk), .csN(csN), .mosi(mosi));
	spi_fault_reporting_logic #(.NOUT(8), .FILT_C(10)) i_dut (.ref_clk(ref_clk), .srst(srst), .sclk(sclk),
		.csN(csN), .mosi(mosi), .miso(miso), .openCmp(openCmp), .outCmd(outCmd), .thermFlag(thermFlag),
		.overVolt(overVolt), .underVolt(underVolt), .sleepMode(sleepMode), .calHigh(1'b0), .calLow(1'b0),
		.trimmed(1'b0), .outEnable(outEnable), .pullDownEn(pullDownEn), .retryTwo(retryTwo),
		.ditherAmp(ditherAmp), .ditherFreq(ditherFreq));
	// ========================================
	// Helpers
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic cmd(input addr_t a, input logic [10:0] d);
		i_host.send({a, d});
		wt(8);
	endtask
	task automatic close_out();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ========================================
	// Scenarios
	task automatic t_dither();
		cmd(`ADDR_DRV2_DITHER, 11'h7DA);
		`CHK(retryTwo, 1'b1)
		`CHK({ditherAmp, ditherFreq}, 7'h5A)
		cmd(`ADDR_DRV2_DITHER, 11'h023);
		`CHK({retryTwo, ditherAmp, ditherFreq}, 8'h23)
	endtask
	task automatic t_unused();
		addr_t tbl [3] = '{`ADDR_THERMAL_LIMIT_QUERY, `ADDR_UNUSED_A, `ADDR_UNUSED_B};
		foreach (tbl[i]) begin
			cmd(tbl[i], 11'h7FF);
			`CHK({retryTwo, ditherAmp, ditherFreq, pullDownEn}, 16'h23FF)
		end
	endtask
	task automatic t_therm();
		thermFlag <= 9'h100;
		wt(4);
		cmd(`ADDR_THERMAL_LIMIT_QUERY, 11'h000);
		`CHK(i_dut.reply_r[8:0], 9'h100)
		cmd(`ADDR_UNUSED_A, 11'h000);
		`CHK(miso, 1'b1)
		thermFlag <= 9'h000;
		wt(6);
		`CHK(miso, 1'b0)
	endtask
	task automatic t_openload();
		outCmd <= 8'h02;
		cmd(`ADDR_UNUSED_A, 11'h000);
		openCmp <= 8'h83;
		wt(4);
		`CHK(i_dut.olLatch_r, 8'h00)
		wt(10);
		`CHK(i_dut.olLatch_r, 8'h81)
		openCmp <= 8'h00;
		wt(4);
		`CHK(i_dut.olLatch_r, 8'h81)
		openCmp <= 8'h81;
		cmd(`ADDR_PULLDOWN, 11'h07E);
		`CHK(i_dut.olLatch_r, 8'h00)
	endtask
	task automatic t_sleep();
		sleepMode <= 1'b1;
		wt(6);
		`CHK(pullDownEn, 8'h00)
		sleepMode <= 1'b0;
		cmd(`ADDR_PULLDOWN, 11'h0FF);
		`CHK(pullDownEn, 8'hFF)
	endtask
	task automatic t_volt();
		outCmd <= 8'hC3;
		wt(6);
		`CHK(outEnable, 8'hC3)
		overVolt <= 1'b1;
		wt(6);
		`CHK(outEnable, 8'h00)
		cmd(`ADDR_UNUSED_A, 11'h000);
		cmd(`ADDR_UNUSED_B, 11'h000);
		`CHK(miso, 1'b1)
		overVolt <= 1'b0;
		wt(6);
		`CHK(outEnable, 8'hC3)
	endtask
	task automatic t_under();
		cmd(`ADDR_PULLDOWN, 11'h05A);
		`CHK(pullDownEn, 8'h5A)
		underVolt <= 1'b1;
		wt(6);
		`CHK({outEnable, pullDownEn}, 16'h00FF)
		`CHK({retryTwo, ditherAmp, ditherFreq}, 8'h00)
		underVolt <= 1'b0;
		wt(6);
	endtask
	// ========================================
	// Main
	initial begin
		wt(4);
		srst <= 1'b0;
		wt(4);
		`CHK({outEnable, pullDownEn}, {8'h00, `PD_RESET})
		t_dither();
		t_unused();
		t_therm();
		t_volt();
		t_under();
		t_openload();
		t_sleep();
		close_out();
	end
	// Well beyond the few tens of microseconds the frames need
	initial begin
		#3000000;
		errors++;
		close_out();
	end
endmodule
